/* File: pif2_pkg.sv */
// constants shared by the second peripheral interrupt flag block
package pif2_pkg;

  // ------------------------------------------------------------------
  // bus geometry
  // ------------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          FLAG_W      = 8;
  localparam logic [3:0]  BANK_SEL    = 4'h4;
  localparam logic [7:0]  FLAGS_OFS   = 8'h10;
  localparam logic [7:0]  ENABLE_OFS  = 8'h14;
  localparam logic [7:0]  SUMMARY_OFS = 8'h18;

  // ------------------------------------------------------------------
  // flag bit positions
  // ------------------------------------------------------------------
  localparam int SERIAL_PORT_EVENT_BIT = 7;
  localparam int BUS_COLLISION_BIT     = 6;
  localparam int CONVERSION_DONE_BIT   = 5;
  localparam int UNUSED_BIT            = 4;
  localparam int CAPTURE_FOUR_BIT      = 3;
  localparam int CAPTURE_THREE_BIT     = 2;
  localparam int UART_TX_EMPTY_BIT     = 1;
  localparam int UART_RX_FULL_BIT      = 0;

  // ------------------------------------------------------------------
  // reset values and access masks
  // ------------------------------------------------------------------
  localparam logic [7:0] FLAGS_RST   = 8'h02;
  localparam logic [7:0] ENABLE_RST  = 8'h00;
  localparam logic [7:0] FLAGS_RW    = 8'hEC;
  localparam logic [7:0] ENABLE_RW   = 8'hEF;

endpackage : pif2_pkg

/* File: pif2_flag_bank.sv */
// sticky event flags, one cell per RW_MASK bit (other bits read zero), set by hardware, written by software
`timescale 1ns/1ps

module pif2_flag_bank #(
  parameter int         WIDTH    = 8,
  parameter logic [7:0] RW_MASK  = 8'hEC
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // hardware events and software write
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic             wr_en_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  // flag state
  output logic      [WIDTH-1:0] flags_o
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
    $error("pif2_flag_bank: WIDTH must be 1 to 8");
  end

  // ------------------------------------------------------------------
  // cells
  // ------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++) begin : g_cell
    if (RW_MASK[i]) begin : g_rw
      logic flag_q;
      logic flag_d;
      // a set in the same cycle as a clearing write wins
      assign flag_d = set_i[i] | (wr_en_i ? wr_data_i[i] : flag_q);
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          flag_q <= 1'b0;
        end else begin
          flag_q <= flag_d;
        end
      end
      assign flags_o[i] = flag_q;
    end else begin : g_none
      assign flags_o[i] = 1'b0;
    end
  end

endmodule : pif2_flag_bank

/* File: pif2_regs.sv */
// second peripheral interrupt flag register with Avalon-MM slave port
//
// Notes on behaviour
// R1: flag register at 10h in bank 4
// R2: serial port flag sticks until software clears
// R3: serial port flag on byte transfer done
// R4: serial port flag on master condition done
// R5: serial port flag on start while idle
// R6: serial port flag on stop while idle
// R7: collision flag only in I2C master mode
// R8: conversion flag set when conversion finishes
// R9: bit 4 always reads zero
// R10: reset value 02h, bits 1:0 read-only
// R11: serial port flag zero without events
// R12: flags set regardless of enable bits
// R13: summary is OR of flags ANDed with enables
// R14: capture four/three set bits 3/2
// R15: bits 1:0 follow second uart buffers
`timescale 1ns/1ps

module pif2_regs #(
  parameter int ADDR_W = pif2_pkg::ADDR_W
) (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic              read_i,
  input  wire logic              write_i,
  input  wire logic [31:0]       writedata_i,
  input  wire logic [3:0]        byteenable_i,
  output logic      [31:0]       readdata_o,
  output logic                   waitrequest_o,
  // sync serial port events
  input  wire logic              ssp_xfer_done_i,
  input  wire logic              ssp_i2c_master_i,
  input  wire logic              ssp_cond_done_i,
  input  wire logic              ssp_idle_i,
  input  wire logic              ssp_start_seen_i,
  input  wire logic              ssp_stop_seen_i,
  input  wire logic              ssp_collision_i,
  // converter and capture events
  input  wire logic              adc_done_i,
  input  wire logic              capture_four_i,
  input  wire logic              capture_three_i,
  // second uart buffer state
  input  wire logic              uart2_tx_empty_i,
  input  wire logic              uart2_rx_full_i,
  // flag outputs
  output logic      [7:0]        flags_o,
  output logic                   peripheral_summary_flag_o
);

  // ------------------------------------------------------------------
  // parameter check
  // ------------------------------------------------------------------
  if (ADDR_W != 12) begin : g_bad_addr
    $error("pif2_regs: ADDR_W must be 12");
  end

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------------
  // every access waits exactly one cycle, then completes
  logic ack_q;
  wire  acc_req   = read_i | write_i;
  wire  acc_first = acc_req & ~ack_q;
  wire  acc_done  = acc_req & ack_q;

  assign waitrequest_o = acc_first;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= acc_first;
    end
  end

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  wire [3:0] bank_w  = address_i[11:8];
  wire [7:0] ofs_w   = address_i[7:0];
  wire       bank_ok = (bank_w == pif2_pkg::BANK_SEL);
  wire       hit_flg = bank_ok & (ofs_w == pif2_pkg::FLAGS_OFS); // R1
  wire       hit_en  = bank_ok & (ofs_w == pif2_pkg::ENABLE_OFS);
  wire       hit_sum = bank_ok & (ofs_w == pif2_pkg::SUMMARY_OFS);
  wire       wr_low  = write_i & acc_done & byteenable_i[0];
  wire       wr_flg  = wr_low & hit_flg;
  wire       wr_en   = wr_low & hit_en;

  // ------------------------------------------------------------------
  // event collection
  // ------------------------------------------------------------------
  // no enable term below: flags latch even when masked
  wire ssp_xfer  = ssp_xfer_done_i; // R3
  wire ssp_cond  = ssp_i2c_master_i & ssp_cond_done_i; // R4
  wire ssp_start = ssp_idle_i & ssp_start_seen_i; // R5
  wire ssp_stop  = ssp_idle_i & ssp_stop_seen_i; // R6
  wire ssp_set   = ssp_xfer | ssp_cond | ssp_start | ssp_stop; // R11
  wire coll_set  = ssp_i2c_master_i & ssp_collision_i; // R7

  wire [7:0] set_vec = {ssp_set,           // R12
                        coll_set,
                        adc_done_i,        // R8
                        1'b0,              // R9
                        capture_four_i,    // R14
                        capture_three_i,
                        2'b00};

  // ------------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------------
  logic [7:0] sticky_w;

  pif2_flag_bank #(
    .WIDTH   (pif2_pkg::FLAG_W),
    .RW_MASK (pif2_pkg::FLAGS_RW)
  ) u_bank (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_q),
    .set_i     (set_vec),
    .wr_en_i   (wr_flg),
    .wr_data_i (writedata_i[7:0]),
    .flags_o   (sticky_w)
  ); // R2

  // ------------------------------------------------------------------
  // hardware-owned uart bits
  // ------------------------------------------------------------------
  // bits 1:0 ignore writes; they only mirror buffer state
  logic tx_empty_q;
  logic rx_full_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_empty_q <= pif2_pkg::FLAGS_RST[pif2_pkg::UART_TX_EMPTY_BIT]; // R10
      rx_full_q  <= pif2_pkg::FLAGS_RST[pif2_pkg::UART_RX_FULL_BIT];
    end else begin
      tx_empty_q <= uart2_tx_empty_i; // R15
      rx_full_q  <= uart2_rx_full_i;
    end
  end

  wire [7:0] flags_w = sticky_w | {6'h00, tx_empty_q, rx_full_q};

  assign flags_o = flags_w;

  // ------------------------------------------------------------------
  // enable register and summary
  // ------------------------------------------------------------------
  logic [7:0] enable_q;
  logic       summary_q;
  wire  [7:0] en_wdata = writedata_i[7:0] & pif2_pkg::ENABLE_RW;
  wire        summary_d = |(flags_w & enable_q); // R13

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      enable_q  <= pif2_pkg::ENABLE_RST;
      summary_q <= 1'b0;
    end else begin
      enable_q  <= wr_en ? en_wdata : enable_q;
      summary_q <= summary_d;
    end
  end

  assign peripheral_summary_flag_o = summary_q;

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  // unmapped addresses read as zero and ignore writes
  wire [7:0] rd_byte = hit_flg ? flags_w :
                       hit_en  ? enable_q :
                       hit_sum ? {7'h00, summary_q} : 8'h00;
  logic [31:0] rdata_q;

  always_ff @(posedge clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata_q <= 32'h0000_0000;
    end else if (read_i & acc_first) begin
      rdata_q <= {24'h00_0000, rd_byte};
    end
  end

  assign readdata_o = rdata_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_q);

  chk_sticky_hold: assert property ( // R2
    flags_w[7] && !wr_flg |=> flags_w[7]
  ) else $error("serial port flag dropped without a write");

  chk_xfer_sets: assert property ( // R3
    ssp_xfer_done_i |=> flags_w[7]
  ) else $error("transfer done did not set serial port flag");

  chk_cond_sets: assert property ( // R4
    ssp_i2c_master_i && ssp_cond_done_i |=> flags_w[7]
  ) else $error("condition done did not set serial port flag");

  chk_start_idle: assert property ( // R5
    ssp_idle_i && ssp_start_seen_i |=> flags_w[7]
  ) else $error("idle start did not set serial port flag");

  chk_stop_idle: assert property ( // R6
    ssp_idle_i && ssp_stop_seen_i |=> flags_w[7]
  ) else $error("idle stop did not set serial port flag");

  chk_coll_cause: assert property ( // R7
    $rose(flags_w[6]) |->
      $past(ssp_i2c_master_i && ssp_collision_i) ||
      $past(wr_flg && writedata_i[6])
  ) else $error("collision flag rose without cause");

  chk_coll_sets: assert property ( // R7
    ssp_i2c_master_i && ssp_collision_i |=> flags_w[6]
  ) else $error("collision did not set flag");

  chk_conv_sets: assert property ( // R8
    adc_done_i |=> flags_w[5]
  ) else $error("conversion done did not set flag");

  chk_bit4_zero: assert property ( // R9
    read_i && acc_done |-> readdata_o[4] == 1'b0 || !hit_flg
  ) else $error("unimplemented bit read as one");

  chk_uart_track: assert property ( // R15
    ##1 flags_w[1:0] == $past({uart2_tx_empty_i, uart2_rx_full_i})
  ) else $error("uart bits do not follow buffer state");

  chk_ssp_cause: assert property ( // R11
    $rose(flags_w[7]) |-> $past(ssp_set) || $past(wr_flg && writedata_i[7])
  ) else $error("serial port flag rose without cause");

  chk_set_wins: assert property ( // R12
    capture_four_i && wr_flg && !writedata_i[3] |=> flags_w[3]
  ) else $error("clearing write beat a capture event");

  chk_summary: assert property ( // R13
    ##1 summary_q == $past(|(flags_w & enable_q))
  ) else $error("summary flag wrong");

  chk_capture: assert property ( // R14
    capture_three_i |=> flags_w[2]
  ) else $error("capture three did not set flag");

  chk_flag_read: assert property ( // R1
    read_i && acc_first && hit_flg |=> readdata_o[7:0] == $past(flags_w)
  ) else $error("flag register read wrong value");

  chk_wait_once: assert property (
    acc_first |=> !waitrequest_o
  ) else $error("waitrequest held more than one cycle");

  chk_four_sets: assert property ( // R14
    capture_four_i |=> flags_w[3]
  ) else $error("capture four did not set flag");

  chk_hi_zero: assert property ( // R1
    read_i && acc_done |-> readdata_o[31:8] == 24'h00_0000
  ) else $error("upper read data bits not zero");

  chk_ssp_clear: assert property ( // R2
    wr_flg && !writedata_i[7] && !ssp_set |=> !flags_w[7]
  ) else $error("serial port flag not cleared by write");

  chk_conv_masked: assert property ( // R12
    adc_done_i && !enable_q[5] |=> flags_w[5]
  ) else $error("masked conversion event did not set flag");

  chk_coll_slave: assert property ( // R7
    ssp_collision_i && !ssp_i2c_master_i && !flags_w[6] && !wr_flg
      |=> !flags_w[6]
  ) else $error("collision flag set outside master mode");

  // a new request must always see one wait cycle first
  chk_wait_first: assert property (
    $rose(acc_req) |-> waitrequest_o
  ) else $error("new request completed without a wait cycle");

endmodule : pif2_regs

/* File: pif2_periph_model.sv */
// peripheral event source model driving the flag register event pins
`timescale 1ns/1ps

module pif2_periph_model (
  // commands from the bench
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [2:0] code_i,
  input  wire logic       master_i,
  input  wire logic       idle_i,
  input  wire logic       tx_i,
  input  wire logic       rx_i,
  // event pulses, plus serial port mode and idle levels and uart buffer levels
  output logic      [7:0] ev_o,
  output logic      [3:0] lvl_o
);
  // ------------------------------------------------------------------
  // one-cycle event pulses, levels move on the same edge
  // ------------------------------------------------------------------
  logic [7:0] ev_q  = 8'h00;
  logic [3:0] lvl_q = 4'h2;

  always @(posedge clk_i) begin
    ev_q  <= fire_i ? (8'h01 << code_i) : 8'h00;
    lvl_q <= {master_i, idle_i, tx_i, rx_i};
  end

  assign ev_o  = ev_q;
  assign lvl_o = lvl_q;
endmodule : pif2_periph_model

/* File: peripheral_irq_flags_two_tb.sv */
// self-checking bench for the second peripheral interrupt flag register
`timescale 1ns/1ps

module peripheral_irq_flags_two_tb;
  // ------------------------------------------------------------------
  // signals
  // ------------------------------------------------------------------
  logic        clk_i, reset_n, read, write, fire, master, idle, tx, rx;
  logic        waitrequest, summary, ws;
  logic [11:0] address;
  logic [31:0] writedata, readdata, rs;
  logic [7:0]  ev, flags;
  logic [3:0]  lvl;
  logic [2:0]  code;
  int          failures, comparisons, cyc;
  // event table: master, idle, code, expected flag bits
  localparam logic [12:0] TBL [11] = '{
    {2'b00, 3'd0, 8'h80}, {2'b10, 3'd1, 8'h80}, {2'b00, 3'd1, 8'h00},
    {2'b01, 3'd2, 8'h80}, {2'b00, 3'd2, 8'h00}, {2'b01, 3'd3, 8'h80},
    {2'b10, 3'd4, 8'h40}, {2'b00, 3'd4, 8'h00}, {2'b00, 3'd5, 8'h20},
    {2'b00, 3'd6, 8'h08}, {2'b00, 3'd7, 8'h04}};

  pif2_regs u_pif2_regs (
    .clk_i(clk_i), .reset_n_i(reset_n), .address_i(address),
    .read_i(read), .write_i(write), .writedata_i(writedata),
    .byteenable_i(4'hF), .readdata_o(readdata),
    .waitrequest_o(waitrequest), .ssp_xfer_done_i(ev[0]),
    .ssp_i2c_master_i(lvl[3]), .ssp_cond_done_i(ev[1]),
    .ssp_idle_i(lvl[2]), .ssp_start_seen_i(ev[2]),
    .ssp_stop_seen_i(ev[3]), .ssp_collision_i(ev[4]),
    .adc_done_i(ev[5]), .capture_four_i(ev[6]),
    .capture_three_i(ev[7]), .uart2_tx_empty_i(lvl[1]),
    .uart2_rx_full_i(lvl[0]), .flags_o(flags),
    .peripheral_summary_flag_o(summary));

  pif2_periph_model u_pif2_periph_model (
    .clk_i(clk_i), .fire_i(fire), .code_i(code), .master_i(master),
    .idle_i(idle), .tx_i(tx), .rx_i(rx), .ev_o(ev), .lvl_o(lvl));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // settled copies of the slave answer, taken mid-cycle
  always @(negedge clk_i) begin
    ws = waitrequest;
    rs = readdata;
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end

  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    address   <= a;
    writedata <= d;
    read      <= ~wr;
    write     <= wr;
    do @(posedge clk_i); while (ws !== 1'b0);
    q = rs;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask : rd

  task automatic fire_ev(input logic [12:0] e);
    @(posedge clk_i);
    master <= e[12];
    idle   <= e[11];
    code   <= e[10:8];
    fire   <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : fire_ev

  task automatic give_verdict();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // ------------------------------------------------------------------
  // tests
  // ------------------------------------------------------------------
  initial begin
    {reset_n, read, write, fire, master, idle, rx} = 7'h00;
    tx = 1'b1;
    address = 12'h000;
    writedata = 32'h0;
    code = 3'h0;
    failures = 0;
    comparisons = 0;
    cyc = 0;
    repeat (12) @(posedge clk_i);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({24'h0, flags}, 32'h02);
    chk({31'h0, summary}, 32'h0);
    rd(12'h410, 32'h02);
    $display("test reset done");
    wr(12'h410, 32'hFF);
    rd(12'h410, 32'hEE);
    wr(12'h410, 32'h00);
    rd(12'h410, 32'h02);
    wr(12'h310, 32'hFF);
    rd(12'h410, 32'h02);
    rd(12'h420, 32'h00);
    $display("test access done");
    // enables stay clear, so every set below also shows independence
    for (int k = 0; k < 11; k++) begin
      fire_ev(TBL[k]);
      rd(12'h410, {24'h0, TBL[k][7:0] | 8'h02});
      wr(12'h410, 32'h00);
      rd(12'h410, 32'h02);
    end
    // capture pulse lands on the same edge as a clearing write
    fork
      wr(12'h410, 32'h00);
      begin
        @(posedge clk_i);
        code <= 3'h6;
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
      end
    join
    rd(12'h410, 32'h0A);
    $display("test events done");
    wr(12'h414, 32'h20);
    rd(12'h418, 32'h00);
    fire_ev(TBL[8]);
    rd(12'h418, 32'h01);
    chk({31'h0, summary}, 32'h1);
    wr(12'h410, 32'h00);
    wr(12'h414, 32'h02);
    rd(12'h418, 32'h01);
    $display("test summary done");
    @(posedge clk_i);
    tx <= 1'b0;
    rx <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(12'h410, 32'h01);
    $display("test uart done");
    give_verdict();
  end
endmodule : peripheral_irq_flags_two_tb
